/* File: core/kpm_defs.svh */
// Purpose: Constants of the keypad parameter menu.
// Assumes: Clock of 20 MHz; values in tenths of a degree unless noted.
// Notes: Included by the package and the menu module.
//
// Function
// - Init routine with startup indication, then temperature.
// - Backlight colour follows the alarm states.
// - Select picks item; up and down change value.
// - Changed values take effect at once.
// - Ten idle seconds return to object temperature.
// - Select from temperature view recalls last item.
// - Peak and valley hold never both active.
// - Down then select held 3 s restores defaults.
// - Six output modes, default zero to five volts.
// - Emissivity, transmissivity 0.100 to 1.100 with defaults.
// - Averaging inactive or 0.1 to 999.9 s.
// - Peak hold inactive, timed or infinite.
// - Valley hold inactive, timed or infinite.
// - Range limits default to 0 and 500.
// - Range limits locked in thermocouple modes.
// - Output limits default 0 and 5 V, follow mode.
// - Unit Celsius or Fahrenheit, Celsius by default.
// - Alarm limits default to 30 and 100.
// - Ambient compensation head or fixed -40 to 900.
// - Address 01 to 32, down at 01 selects RS422.
// - Five baud rates, default 9.6 kBaud.
// - Laser setting drives the switched supply pin.
// - Read-only views of four measured temperatures.
// - Alarms switch with 2 K hysteresis.
`ifndef KPM_DEFS_SVH
`define KPM_DEFS_SVH
`define CLK_HZ      20000000
`define INIT_S      2
`define IDLE_S      10
`define CHORD_S     3
`define RSHOW_S     1
`define N_ITEMS     21
`define I_OBJ       5'h00
`define I_MODE      5'h04
`define I_EMIS      5'h05
`define I_TRANS     5'h06
`define I_AVG       5'h07
`define I_PEAK      5'h08
`define I_VAL       5'h09
`define I_RLO       5'h0a
`define I_RHI       5'h0b
`define I_OLO       5'h0c
`define I_OHI       5'h0d
`define I_UNIT      5'h0e
`define I_ALO       5'h0f
`define I_AHI       5'h10
`define I_AMB       5'h11
`define I_ADDR      5'h12
`define I_BAUD      5'h13
`define I_LASER     5'h14
`define A_STAT      5'h1f
`define M_TCJ       16'h0004
`define M_MAX       16'h0005
`define M_CUR0      16'h0000
`define M_CUR4      16'h0001
`define M_V10       16'h0003
`define EMIS_MIN    16'h0064
`define EMIS_MAX    16'h044c
`define TIME_MAX    16'h270f
`define HOLD_INF    16'h2710
`define RNG_MIN     16'hfe70
`define RNG_MAX     16'h2328
`define AMB_MIN     16'hfe70
`define AMB_MAX     16'h2328
`define OUT_MA      16'h07d0
`define OUT_V5      16'h01f4
`define OUT_V10     16'h03e8
`define ADDR_MAX    16'h0020
`define BAUD_MAX    16'h0004
`define BIT_MAX     16'h0001
`define HYST        16'h0014
`define D_MODE      16'h0002
`define D_EMIS      16'h03ca
`define D_TRANS     16'h03e8
`define D_AVG       16'h0002
`define D_RHI       16'h1388
`define D_OHI       16'h01f4
`define D_ALO       16'h012c
`define D_AHI       16'h03e8
`define D_ADDR      16'h0001
`define BL_GREEN    2'h0
`define BL_BLUE     2'h1
`define BL_RED      2'h2
`endif

/* File: core/kpm_pkg.sv */
// Purpose: Types of the keypad parameter menu.
// Assumes: Constants come from kpm_defs.svh.
// Notes: Parameter words are signed 16-bit fixed point.
`include "kpm_defs.svh"
package kpm_pkg;
  typedef enum logic [3:0] {
    ST_INIT  = 4'h1,
    ST_TEMP  = 4'h2,
    ST_MENU  = 4'h4,
    ST_RESET = 4'h8
  } mstate_t;
  typedef struct packed {
    logic sel;
    logic up;
    logic dn;
  } keys_t;
  typedef struct packed {
    logic [15:0] obj;
    logic [15:0] head;
    logic [15:0] box;
    logic [15:0] raw;
  } temps_t;
  typedef struct packed {
    logic        init;
    logic        reset;
    logic [4:0]  item;
    logic [15:0] value;
  } disp_t;
  typedef logic [`N_ITEMS-1:0][15:0] par_t;
  typedef struct packed {
    mstate_t     st;
    logic [27:0] tmr;
    logic [27:0] idle;
    logic [27:0] chord;
    logic        armed;
    keys_t       kprev;
    logic [4:0]  item;
    logic [4:0]  last;
    par_t        par;
    logic        head_comp;
    logic        al1;
    logic        al2;
    logic [1:0]  bl;
    logic        laser;
    disp_t       disp;
    logic [15:0] rdata;
  } state_t;
endpackage

/* File: core/keypad_parameter_menu.sv */
// Purpose: Three-key setup menu, parameter store and alarm colour.
// Assumes: Keys and temperatures synchronous to clk; keys are high when pressed.
// Notes: Word address = item index; status word at A_STAT.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "kpm_defs.svh"
module keypad_parameter_menu #(
  parameter int unsigned INIT_CYC  = `INIT_S * `CLK_HZ,
  parameter int unsigned IDLE_CYC  = `IDLE_S * `CLK_HZ,
  parameter int unsigned CHORD_CYC = `CHORD_S * `CLK_HZ,
  parameter int unsigned RSHOW_CYC = `RSHOW_S * `CLK_HZ
) (
  input  wire  logic            clk,
  input  wire  logic            arst_n,
  input  wire  kpm_pkg::keys_t  keys,
  input  wire  kpm_pkg::temps_t temps,
  input  wire  logic            laser_menu_first,
  input  wire  logic [4:0]      addr,
  input  wire  logic [15:0]     wdata,
  input  wire  logic            wr,
  input  wire  logic            rd,
  output logic [15:0]           rdata,
  output kpm_pkg::disp_t        disp,
  output logic [1:0]            backlight,
  output logic                  alarm1,
  output logic                  alarm2,
  output logic                  laser_switched_supply_pin,
  output logic                  head_temp_compensation,
  output kpm_pkg::par_t         params
);
  import kpm_pkg::*;

  state_t s_r;
  state_t s_nxt;

  localparam logic [27:0] INIT_END  = 28'(INIT_CYC - 1);
  localparam logic [27:0] IDLE_END  = 28'(IDLE_CYC - 1);
  localparam logic [27:0] CHORD_END = 28'(CHORD_CYC - 1);
  localparam logic [27:0] RSHOW_END = 28'(RSHOW_CYC - 1);

  // Factory value of one item.
  function automatic logic [15:0] dflt(input logic [4:0] i);
    logic [15:0] v;
    v = 16'h0000;
    if (i == `I_MODE) begin
      v = `D_MODE;
    end else if (i == `I_EMIS) begin
      v = `D_EMIS;
    end else if (i == `I_TRANS) begin
      v = `D_TRANS;
    end else if (i == `I_AVG) begin
      v = `D_AVG;
    end else if (i == `I_RHI) begin
      v = `D_RHI;
    end else if (i == `I_OHI) begin
      v = `D_OHI;
    end else if (i == `I_ALO) begin
      v = `D_ALO;
    end else if (i == `I_AHI) begin
      v = `D_AHI;
    end else if (i == `I_ADDR) begin
      v = `D_ADDR;
    end
    return v;
  endfunction

  // Span of the output limits for a mode.
  function automatic logic [15:0] out_max(input logic [15:0] m);
    logic [15:0] v;
    v = `OUT_V5;
    if (m == `M_CUR0 || m == `M_CUR4) begin
      v = `OUT_MA;
    end else if (m == `M_V10) begin
      v = `OUT_V10;
    end
    return v;
  endfunction

  // Lowest allowed value of an item.
  function automatic logic signed [15:0] lo_of(input logic [4:0] i);
    logic signed [15:0] v;
    v = 16'sh0000;
    if (i == `I_EMIS || i == `I_TRANS) begin
      v = `EMIS_MIN;
    end else if (i == `I_RLO || i == `I_RHI || i == `I_ALO || i == `I_AHI) begin
      v = `RNG_MIN;
    end else if (i == `I_AMB) begin
      v = `AMB_MIN;
    end
    return v;
  endfunction

  // Highest allowed value of an item.
  function automatic logic signed [15:0] hi_of(input logic [4:0] i,
                                              input logic [15:0] m);
    logic signed [15:0] v;
    v = `BIT_MAX;
    if (i == `I_MODE) begin
      v = `M_MAX;
    end else if (i == `I_EMIS || i == `I_TRANS) begin
      v = `EMIS_MAX;
    end else if (i == `I_AVG) begin
      v = `TIME_MAX;
    end else if (i == `I_PEAK || i == `I_VAL) begin
      v = `HOLD_INF;
    end else if (i == `I_RLO || i == `I_RHI || i == `I_ALO || i == `I_AHI) begin
      v = `RNG_MAX;
    end else if (i == `I_OLO || i == `I_OHI) begin
      v = out_max(m);
    end else if (i == `I_AMB) begin
      v = `AMB_MAX;
    end else if (i == `I_ADDR) begin
      v = `ADDR_MAX;
    end else if (i == `I_UNIT) begin
      v = `BIT_MAX;
    end else if (i == `I_BAUD) begin
      v = `BAUD_MAX;
    end
    return v;
  endfunction

  // Clamps a value into the span of an item.
  function automatic logic [15:0] clamp(input logic [4:0] i,
                                        input logic [15:0] m,
                                        input logic signed [15:0] x);
    logic signed [15:0] v;
    v = x;
    if (x < lo_of(i)) begin
      v = lo_of(i);
    end else if (x > hi_of(i, m)) begin
      v = hi_of(i, m);
    end
    return v;
  endfunction

  // Menu order; the laser item leads on some variants.
  function automatic logic [4:0] next_item(input logic [4:0] i,
                                           input logic lf);
    logic [4:0] v;
    v = i + 5'h01;
    if (i == `I_OBJ && lf) begin
      v = `I_LASER;
    end else if (i == `I_LASER && lf) begin
      v = 5'h01;
    end else if (i == `I_LASER) begin
      v = `I_OBJ;
    end else if (i == `I_ADDR + 5'h01 && lf) begin
      v = `I_OBJ;
    end
    return v;
  endfunction

  keys_t              kp;
  logic [15:0]        mode;
  logic               tc;
  logic signed [15:0] obj;
  logic signed [15:0] v;
  logic               adj;

  // Keys act on the edge at which they rise, so a held key never repeats a
  // step; only the chord, the two-key compensation and the idle timer look at levels.
  always_comb begin
    s_nxt = s_r;
    kp    = keys & ~s_r.kprev;
    mode  = s_r.par[`I_MODE];
    tc    = mode >= `M_TCJ;
    obj   = temps.obj;
    v     = s_r.par[s_r.item];
    adj   = 1'b0;
    s_nxt.kprev = keys;
    case (s_r.st)
      ST_INIT: begin
        s_nxt.tmr = s_r.tmr + 28'h0000001;
        if (s_r.tmr >= INIT_END) begin
          s_nxt.st   = ST_TEMP;
          s_nxt.item = `I_OBJ;
        end
      end
      ST_RESET: begin
        // Keys are ignored while the confirmation shows.
        s_nxt.tmr = s_r.tmr + 28'h0000001;
        if (s_r.tmr >= RSHOW_END) begin
          s_nxt.st   = ST_TEMP;
          s_nxt.item = `I_OBJ;
        end
      end
      default: begin
        // A held key keeps the idle timer at zero.
        if (keys != 3'b000) begin
          s_nxt.idle = 28'h0000000;
        end else if (s_r.idle < IDLE_END) begin
          s_nxt.idle = s_r.idle + 28'h0000001;
        end else begin
          s_nxt.st   = ST_TEMP;
          s_nxt.item = `I_OBJ;
        end
        // The chord is armed only when select follows a held down key.
        // Down pressed alone first may still step the shown value.
        if (kp.sel && keys.dn && s_r.kprev.dn) begin
          s_nxt.armed = 1'b1;
        end else if (!(keys.sel && keys.dn)) begin
          s_nxt.armed = 1'b0;
        end
        s_nxt.chord = s_r.armed ? s_r.chord + 28'h0000001 : 28'h0000000;
        if (s_r.armed && s_r.chord >= CHORD_END) begin
          for (int i = 0; i < `N_ITEMS; i++) begin
            s_nxt.par[i] = dflt(5'(i));
          end
          s_nxt.head_comp = 1'b1;
          s_nxt.armed     = 1'b0;
          s_nxt.st        = ST_RESET;
          s_nxt.tmr       = 28'h0000000;
          s_nxt.last      = `I_OBJ;
        end else if (kp.sel && !keys.dn) begin
          if (s_r.st == ST_TEMP) begin
            s_nxt.item = (s_r.last == `I_OBJ) ?
                         next_item(`I_OBJ, laser_menu_first) : s_r.last;
          end else begin
            s_nxt.item = next_item(s_r.item, laser_menu_first);
          end
          s_nxt.last = s_nxt.item;
          s_nxt.st   = ST_MENU;
        end else if (s_r.st == ST_MENU && s_r.item >= `I_MODE && !keys.sel) begin
          if (s_r.item == `I_AMB && keys.up && keys.dn && (kp.up || kp.dn)) begin
            s_nxt.head_comp = 1'b1;
          end else if (kp.up && v < hi_of(s_r.item, mode)) begin
            v   = v + 16'sh0001;
            adj = 1'b1;
          end else if (kp.dn && v > lo_of(s_r.item)) begin
            v   = v - 16'sh0001;
            adj = 1'b1;
          end
          if ((s_r.item == `I_RLO || s_r.item == `I_RHI) && tc) begin
            adj = 1'b0;
          end
        end
      end
    endcase
    // Software writes share the key path and its limits.
    if (wr && addr >= `I_MODE && addr <= `I_LASER && !(tc &&
        (addr == `I_RLO || addr == `I_RHI))) begin
      s_nxt.par[addr] = clamp(addr, mode, wdata);
      if (addr == `I_AMB) begin
        s_nxt.head_comp = 1'b0;
      end
      // A nonzero hold time clears the other hold.
      if (addr == `I_PEAK && wdata != 16'h0000) begin
        s_nxt.par[`I_VAL] = 16'h0000;
      end else if (addr == `I_VAL && wdata != 16'h0000) begin
        s_nxt.par[`I_PEAK] = 16'h0000;
      end
    end else if (adj) begin
      s_nxt.par[s_r.item] = v;
      if (s_r.item == `I_AMB) begin
        s_nxt.head_comp = 1'b0;
      end
      if (s_r.item == `I_PEAK && v != 16'sh0000) begin
        s_nxt.par[`I_VAL] = 16'h0000;
      end else if (s_r.item == `I_VAL && v != 16'sh0000) begin
        s_nxt.par[`I_PEAK] = 16'h0000;
      end
    end
    // Output limits follow a change of output mode.
    s_nxt.par[`I_OLO] = clamp(`I_OLO, s_nxt.par[`I_MODE], s_nxt.par[`I_OLO]);
    s_nxt.par[`I_OHI] = clamp(`I_OHI, s_nxt.par[`I_MODE], s_nxt.par[`I_OHI]);
    // Set wins over release; the band between them keeps the last state.
    // Low alarm on alarm 1, high alarm on alarm 2.
    if (obj < $signed(s_r.par[`I_ALO])) begin
      s_nxt.al1 = 1'b1;
    end else if (obj >= $signed(s_r.par[`I_ALO] + `HYST)) begin
      s_nxt.al1 = 1'b0;
    end
    if (obj > $signed(s_r.par[`I_AHI])) begin
      s_nxt.al2 = 1'b1;
    end else if (obj <= $signed(s_r.par[`I_AHI] - `HYST)) begin
      s_nxt.al2 = 1'b0;
    end
    s_nxt.bl = s_r.al2 ? `BL_RED : (s_r.al1 ? `BL_BLUE : `BL_GREEN);
    s_nxt.laser = s_r.par[`I_LASER][0];
    // The display follows the registered state, one cycle behind it.
    s_nxt.disp.init  = (s_r.st == ST_INIT);
    s_nxt.disp.reset = (s_r.st == ST_RESET);
    s_nxt.disp.item  = s_r.item;
    if (s_r.item == 5'h00) begin
      s_nxt.disp.value = temps.obj;
    end else if (s_r.item == 5'h01) begin
      s_nxt.disp.value = temps.head;
    end else if (s_r.item == 5'h02) begin
      s_nxt.disp.value = temps.box;
    end else if (s_r.item == 5'h03) begin
      s_nxt.disp.value = temps.raw;
    end else begin
      s_nxt.disp.value = s_r.par[s_r.item];
    end
    // Read data stand in the cycle after the strobe only.
    s_nxt.rdata = 16'h0000;
    if (rd) begin
      if (addr == 5'h00) begin
        s_nxt.rdata = temps.obj;
      end else if (addr == 5'h01) begin
        s_nxt.rdata = temps.head;
      end else if (addr == 5'h02) begin
        s_nxt.rdata = temps.box;
      end else if (addr == 5'h03) begin
        s_nxt.rdata = temps.raw;
      end else if (addr <= `I_LASER) begin
        s_nxt.rdata = s_r.par[addr];
      end else if (addr == `A_STAT) begin
        s_nxt.rdata = {s_r.st, s_r.item, s_r.head_comp, tc, s_r.al2,
                       s_r.al1, s_r.armed, s_r.bl};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.st <= ST_INIT;
      s_r.head_comp <= 1'b1;
      s_r.par[`I_MODE]  <= `D_MODE;
      s_r.par[`I_EMIS]  <= `D_EMIS;
      s_r.par[`I_TRANS] <= `D_TRANS;
      s_r.par[`I_AVG]   <= `D_AVG;
      s_r.par[`I_RHI]   <= `D_RHI;
      s_r.par[`I_OHI]   <= `D_OHI;
      s_r.par[`I_ALO]   <= `D_ALO;
      s_r.par[`I_AHI]   <= `D_AHI;
      s_r.par[`I_ADDR]  <= `D_ADDR;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata                     = s_r.rdata;
  assign disp                      = s_r.disp;
  assign backlight                 = s_r.bl;
  assign alarm1                    = s_r.al1;
  assign alarm2                    = s_r.al2;
  assign laser_switched_supply_pin = s_r.laser;
  assign head_temp_compensation    = s_r.head_comp;
  assign params                    = s_r.par;
endmodule // keypad_parameter_menu
`default_nettype wire

/* File: tb/kpm_check_sva.sv */
// Purpose: Port checks on the keypad parameter menu.
// Assumes: The bind hands over the shortened init and idle counts.
// Notes: The bind statement stands at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
`include "kpm_defs.svh"
module kpm_check #(
  parameter int unsigned INIT_CYC = 20,
  parameter int unsigned IDLE_CYC = 50
) (
  input wire logic            clk,
  input wire logic            arst_n,
  input wire kpm_pkg::keys_t  keys,
  input wire kpm_pkg::temps_t temps,
  input wire kpm_pkg::disp_t  disp,
  input wire logic [1:0]      backlight,
  input wire logic            alarm1,
  input wire logic            alarm2,
  input wire logic            laser_switched_supply_pin,
  input wire kpm_pkg::par_t   params
);
  import kpm_pkg::*;
  int unsigned since_r;
  int unsigned idle_r;
  logic [1:0]  bl_exp;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  always_comb bl_exp = alarm2 ? `BL_RED : (alarm1 ? `BL_BLUE : `BL_GREEN);
  // Both counters saturate so they never wrap back into a trigger value.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_r <= 0;
      idle_r  <= 0;
    end else begin
      if (since_r < 1000) since_r <= since_r + 1;
      if (keys != 3'b000) idle_r <= 0;
      else if (idle_r < 1000) idle_r <= idle_r + 1;
    end
  end
  sequence s_sel_press;
    !keys.sel ##1 keys.sel;
  endsequence
  sequence s_init_done;
    disp.init ##5 (!disp.init && disp.item == 5'h00);
  endsequence
  AST_INIT_END: assert property (since_r == INIT_CYC - 2 |-> s_init_done)
    else $error("startup indication has the wrong length");
  AST_BACKLIGHT: assert property ($stable({alarm1, alarm2}) |-> backlight == bl_exp)
    else $error("backlight colour does not follow the alarms");
  AST_SEL_STEP: assert property (s_sel_press ##0 !(keys.up || keys.dn || disp.init || disp.reset)
    |-> ##2 disp.item != $past(disp.item))
    else $error("select key did not change the shown item");
  AST_IDLE_BACK: assert property (idle_r == IDLE_CYC + 4 |-> disp.item == 5'h00)
    else $error("idle timeout did not return to temperature");
  AST_HOLD_EXCL: assert property (params[8] == 16'h0000 || params[9] == 16'h0000)
    else $error("peak and valley hold both active");
  AST_CHORD: assert property ($rose(disp.reset) |-> $past(keys.dn && keys.sel, 3))
    else $error("factory reset without the key chord");
  AST_SPANS: assert property (params[4] <= `M_MAX && params[19] <= `BAUD_MAX
    && params[18] <= `ADDR_MAX && params[5] >= `EMIS_MIN && params[5] <= `EMIS_MAX)
    else $error("parameter outside its span");
  AST_LASER: assert property ($stable(params[20]) |-> laser_switched_supply_pin == params[20][0])
    else $error("laser supply pin disagrees with its setting");
  AST_AL1_SET: assert property ($rose(alarm1)
    |-> $signed($past(temps.obj)) < $signed($past(params[15])))
    else $error("low alarm set above its limit");
  AST_AL2_CLR: assert property ($fell(alarm2)
    |-> $signed($past(temps.obj)) <= $signed($past(params[16])) - 20)
    else $error("high alarm released inside the hysteresis band");
endmodule // kpm_check
bind keypad_parameter_menu kpm_check #(.INIT_CYC(INIT_CYC), .IDLE_CYC(IDLE_CYC)) chk (
  .clk(clk), .arst_n(arst_n), .keys(keys), .temps(temps), .disp(disp),
  .backlight(backlight), .alarm1(alarm1), .alarm2(alarm2),
  .laser_switched_supply_pin(laser_switched_supply_pin), .params(params));
`default_nettype wire

/* File: tb/keypad_operator.sv */
// Purpose: Operator at the three programming keys.
// Assumes: Keys are high while pressed.
// Notes: Every press ends with a release gap so the next press is a fresh edge.
`timescale 1ns/100ps
`default_nettype none
module keypad_operator (
  input  wire logic     clk,
  output kpm_pkg::keys_t keys
);
  import kpm_pkg::*;
  initial keys = '0;
  // Presses the first keys, adds the rest two cycles later, holds, lets go.
  task automatic hold(input keys_t first, input keys_t all, input int n);
    @(posedge clk);
    keys <= first;
    repeat (2) @(posedge clk);
    keys <= all;
    repeat (n) @(posedge clk);
    keys <= '0;
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule // keypad_operator
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the keypad parameter menu.
// Assumes: Shortened init, idle, chord and reset display counts.
// Notes: Keys come from the operator model, registers from the word port.
`timescale 1ns/100ps
`default_nettype none
`include "kpm_defs.svh"
module tb_top;
  import kpm_pkg::*;
  localparam int    INIT  = 20;
  localparam int    IDLE  = 50;
  localparam int    CHORD = 30;
  localparam int    RSHOW = 10;
  localparam keys_t SEL   = 3'b100;
  localparam keys_t UP    = 3'b010;
  localparam keys_t DN    = 3'b001;
  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic        lfirst = 1'b0;
  logic [4:0]  addr   = 5'h00;
  logic [15:0] wdata  = 16'h0000;
  temps_t      temps  = {16'h01f4, 16'h0111, 16'h00fa, 16'h01f0};
  logic [15:0] rdata;
  keys_t       keys;
  disp_t       disp;
  logic [1:0]  backlight;
  logic        alarm1;
  logic        alarm2;
  logic        laser;
  logic        head_comp;
  par_t        params;
  int          fail_count   = 0;
  int          total_checks = 0;
  logic [15:0] dflt [21] = '{0, 0, 0, 0, `D_MODE, `D_EMIS, `D_TRANS, `D_AVG, 0, 0, 0,
                             `D_RHI, 0, `D_OHI, 0, `D_ALO, `D_AHI, 0, `D_ADDR, 0, 0};
  logic [15:0] obj_v [7] = '{16'h01f4, 16'h00c8, 16'h0136, 16'h0140, 16'h044c,
                             16'h03de, 16'h03d4};
  logic [3:0]  al_v [7]  = '{4'h0, 4'h5, 4'h5, 4'h0, 4'ha, 4'ha, 4'h0};

  keypad_operator op (.clk(clk), .keys(keys));
  keypad_parameter_menu #(.INIT_CYC(INIT), .IDLE_CYC(IDLE), .CHORD_CYC(CHORD),
    .RSHOW_CYC(RSHOW)) uut (
    .clk(clk), .arst_n(arst_n), .keys(keys), .temps(temps), .laser_menu_first(lfirst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .disp(disp),
    .backlight(backlight), .alarm1(alarm1), .alarm2(alarm2),
    .laser_switched_supply_pin(laser), .head_temp_compensation(head_comp), .params(params));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, e);
  endtask
  task automatic press(input keys_t k);
    op.hold(k, k, 1);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results;
  end

  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    step(3);
    check(16'(disp.init), 16'h0001);
    step(INIT);
    check(16'({disp.init, disp.item}), 16'h0000);
    check(disp.value, temps.obj);
    for (int a = 4; a < 21; a++) if (a != 17) rd_chk(5'(a), dflt[a]);
    check(16'({head_comp, laser}), 16'h0002);
    for (int a = 0; a < 4; a++) rd_chk(5'(a), temps[63 - 16 * a -: 16]);
    wr_reg(5'h01, 16'h0abc);
    rd_chk(5'h01, temps.head);
    wr_reg(`I_EMIS, 16'h2000);
    rd_chk(`I_EMIS, `EMIS_MAX);
    wr_reg(`I_UNIT, 16'h0005);
    rd_chk(`I_UNIT, `BIT_MAX);
    wr_reg(`I_PEAK, 16'h0005);
    wr_reg(`I_VAL, 16'h0007);
    rd_chk(`I_PEAK, 16'h0000);
    wr_reg(`I_PEAK, 16'h7fff);
    rd_chk(`I_PEAK, `HOLD_INF);
    rd_chk(`I_VAL, 16'h0000);
    wr_reg(`I_MODE, `M_TCJ);
    wr_reg(`I_RLO, 16'h0064);
    rd_chk(`I_RLO, 16'h0000);
    wr_reg(`I_MODE, `D_MODE);
    press(SEL);
    check(16'(disp.item), 16'h0001);
    check(disp.value, temps.head);
    repeat (3) press(SEL);
    check(16'(disp.item), 16'(`I_MODE));
    press(UP);
    check(params[`I_MODE], 16'h0003);
    press(DN);
    check(params[`I_MODE], `D_MODE);
    press(SEL);
    press(UP);
    check(params[`I_EMIS], `EMIS_MAX);
    press(DN);
    check(params[`I_EMIS], 16'h044b);
    step(IDLE + 5);
    check(16'(disp.item), 16'h0000);
    press(SEL);
    check(16'(disp.item), 16'(`I_EMIS));
    for (int i = 0; i < 25 && disp.item !== `I_AMB; i++) press(SEL);
    check(16'(disp.item), 16'(`I_AMB));
    press(UP);
    check(16'(head_comp), 16'h0000);
    press(UP | DN);
    check(16'(head_comp), 16'h0001);
    press(SEL);
    press(DN);
    check(params[`I_ADDR], 16'h0000);
    press(SEL);
    repeat (6) press(UP);
    check(params[`I_BAUD], `BAUD_MAX);
    press(SEL);
    press(UP);
    check(16'(laser), 16'h0001);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      temps.obj <= obj_v[i];
      step(4);
      check(16'({alarm2, alarm1, backlight}), 16'(al_v[i]));
    end
    fork
      op.hold(DN, DN | SEL, CHORD + 2);
      begin
        for (int i = 0; i < 100 && disp.reset !== 1'b1; i++) step(1);
        check(16'(disp.reset), 16'h0001);
      end
    join
    step(RSHOW + 3);
    rd_chk(`I_EMIS, `D_EMIS);
    check(16'({laser, head_comp}), 16'h0001);
    @(posedge clk);
    lfirst <= 1'b1;
    press(SEL);
    check(16'(disp.item), 16'(`I_LASER));
    results;
  end
endmodule // tb_top
`default_nettype wire
